// [logic/dag_top.sv]
// Debug access security gate: identifier check, debug condition gating, AXI4-Lite registers
`timescale 1ns/100ps
module dag_top
    import dag_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [ADDR_W-1:0]      s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic [8*DAG_ID_BYTES-1:0] flash_id,
    input  wire logic                   clocked_serial_clock,
    input  wire logic                   clocked_serial_in,
    output logic                        clocked_serial_out,
    output logic                        handshake_line,
    output logic                        async_serial_tx,
    input  wire logic                   debug_reset_pin,
    input  wire logic                   cpu_int_enable,
    input  wire logic                   standby_active,
    input  wire logic                   standby_mi_release_en,
    input  wire logic                   main_clock_running,
    input  wire logic                   async_rate_ok,
    input  wire logic                   dbg_break_req,
    input  wire logic                   dbg_monitor_req,
    input  wire logic                   dmm_wr_req,
    input  wire logic                   dmm_target_protected,
    output logic                        flash_read_en,
    output logic                        debug_enable,
    output logic                        break_grant,
    output logic                        monitor_grant,
    output logic                        dmm_wr_grant,
    output logic                        dmm_wr_reject,
    output logic                        standby_release
);
    // Pin synchronisers and link byte receiver
    logic [2:0] pins_s;
    logic       rx_valid;
    logic [7:0] rx_byte;
    logic       retry_pulse;

    dag_sync #(.WIDTH(3)) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({debug_reset_pin, clocked_serial_in, clocked_serial_clock}),
        .sync_out (pins_s)
    );

    wire sck_s    = pins_s[0];
    wire sin_s    = pins_s[1];
    wire dreset_s = pins_s[2];

    dag_byte_rx u_rx (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .sck_s      (sck_s),
        .sin_s      (sin_s),
        .clear      (retry_pulse),
        .byte_valid (rx_valid),
        .byte_data  (rx_byte)
    );

    // Stored identifier, captured once after reset release
    logic [8*DAG_ID_BYTES-1:0] flash_id_reg;
    logic                      flash_loaded_reg;
    logic [7:0]                rx_id_mem [DAG_ID_BYTES];
    logic [3:0]                rx_cnt_reg;
    dag_auth_type              state_reg;
    logic                      unlocked_reg;
    logic                      match_reg;
    logic                      tried_reg;

    logic [DAG_ID_BYTES-1:0] byte_eq;
    for (genvar i = 0; i < DAG_ID_BYTES; i++) begin : g_cmp
        assign byte_eq[i] = rx_id_mem[i] == flash_id_reg[8*i +: 8];
    end
    wire id_match = &byte_eq;
    wire en_flag  = flash_id_reg[8*(DAG_ID_BYTES-1) + DAG_EN_FLAG_BIT];
    wire last_rx  = rx_valid && rx_cnt_reg == 4'(DAG_ID_BYTES - 1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flash_id_reg     <= '0;
            flash_loaded_reg <= 1'b0;
        end else if (!flash_loaded_reg) begin
            flash_id_reg     <= flash_id;
            flash_loaded_reg <= 1'b1;
        end
    end

    // First byte received lands in the lowest address slot
    always_ff @(posedge aclk) begin
        if (rx_valid && state_reg != DAG_CHECK) begin
            rx_id_mem[rx_cnt_reg] <= rx_byte;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg    <= DAG_IDLE;
            rx_cnt_reg   <= 4'h0;
            unlocked_reg <= 1'b0;
            match_reg    <= 1'b0;
            tried_reg    <= 1'b0;
        end else if (retry_pulse) begin
            state_reg  <= DAG_IDLE;
            rx_cnt_reg <= 4'h0;
        end else begin
            case (state_reg)
                DAG_IDLE, DAG_RECV: begin
                    if (rx_valid) begin
                        rx_cnt_reg <= rx_cnt_reg + 4'h1;
                        state_reg  <= last_rx ? DAG_CHECK : DAG_RECV;
                    end
                end
                DAG_CHECK: begin
                    // Only the first completed attempt after reset or a retry replaces the verdict
                    unlocked_reg <= id_match && en_flag;
                    match_reg    <= id_match;
                    tried_reg    <= 1'b1;
                    state_reg    <= DAG_HOLD;
                end
                DAG_HOLD: begin
                    rx_cnt_reg <= 4'h0;
                end
                default: state_reg <= DAG_IDLE;
            endcase
        end
    end

    // Software registers
    logic [7:0] ctrl_reg;
    logic [7:0] cb_ric_reg;
    logic [7:0] ua_ric_reg;
    logic [7:0] port4_reg;

    wire mode_sel   = ctrl_reg[DAG_CTRL_MODE_BIT];
    wire link_async = ctrl_reg[DAG_CTRL_LINK_BIT];
    wire [7:0] ric_sel = link_async ? ua_ric_reg : cb_ric_reg;
    wire int_masked = ric_sel[DAG_RIC_MASK_BIT];

    // Debug condition gating
    wire debug_live   = unlocked_reg && !mode_sel;
    wire block_common = !cpu_int_enable || int_masked || (standby_active && !standby_mi_release_en)
                        || (link_async && !main_clock_running);
    wire break_ok     = debug_live && !block_common;
    wire monitor_ok   = break_ok && !(link_async && !async_rate_ok);
    wire wake_ok      = !link_async || main_clock_running;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flash_read_en      <= 1'b0;
            debug_enable       <= 1'b0;
            break_grant        <= 1'b0;
            monitor_grant      <= 1'b0;
            dmm_wr_grant       <= 1'b0;
            dmm_wr_reject      <= 1'b0;
            standby_release    <= 1'b0;
            handshake_line     <= 1'b0;
            clocked_serial_out <= 1'b0;
            async_serial_tx    <= 1'b1;
        end else begin
            flash_read_en      <= unlocked_reg;
            debug_enable       <= debug_live;
            break_grant        <= dbg_break_req && break_ok;
            monitor_grant      <= dbg_monitor_req && monitor_ok;
            // Special-sequence registers cannot be reached this way
            dmm_wr_grant       <= dmm_wr_req && monitor_ok && !dmm_target_protected;
            dmm_wr_reject      <= dmm_wr_req && !(monitor_ok && !dmm_target_protected);
            standby_release    <= (dbg_monitor_req || dmm_wr_req) && monitor_ok && standby_active
                                  && wake_ok;
            handshake_line     <= state_reg != DAG_CHECK;
            clocked_serial_out <= unlocked_reg;
            async_serial_tx    <= 1'b1;
        end
    end

    // AXI4-Lite slave
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0]       w_data_reg;
    logic [3:0]        w_strb_reg;
    logic              aw_have_reg;
    logic              w_have_reg;

    wire       wr_fire  = aw_have_reg && w_have_reg && !s_axi_bvalid;
    wire [7:0] wr_ofs   = 8'(aw_addr_reg);
    wire       wr_lane  = wr_fire && w_strb_reg[0];
    wire       wr_ctrl  = wr_lane && wr_ofs == DAG_OFS_CTRL;
    wire       wr_cb    = wr_lane && wr_ofs == DAG_OFS_CB_RIC;
    wire       wr_ua    = wr_lane && wr_ofs == DAG_OFS_UA_RIC;
    wire       wr_p4    = wr_lane && wr_ofs == DAG_OFS_PORT4;
    wire       wr_known = wr_ofs == DAG_OFS_CTRL || wr_ofs == DAG_OFS_CB_RIC
                          || wr_ofs == DAG_OFS_UA_RIC || wr_ofs == DAG_OFS_PORT4;
    assign retry_pulse  = wr_ctrl && w_data_reg[DAG_CTRL_RETRY_BIT];

    wire [7:0] rd_ofs = 8'(s_axi_araddr);
    wire [7:0] status_byte = {state_reg, tried_reg, rx_cnt_reg == 4'h0, en_flag, match_reg,
                              debug_live, unlocked_reg};
    wire [7:0] cond_byte = {2'h0, wake_ok, int_masked, block_common, monitor_ok, break_ok, dreset_s};
    wire rd_known = rd_ofs == DAG_OFS_CTRL || rd_ofs == DAG_OFS_STATUS || rd_ofs == DAG_OFS_COND
                    || rd_ofs == DAG_OFS_CB_RIC || rd_ofs == DAG_OFS_UA_RIC || rd_ofs == DAG_OFS_PORT4;
    wire [7:0] rd_byte = rd_ofs == DAG_OFS_CTRL   ? {6'h00, ctrl_reg[1:0]} :
                         rd_ofs == DAG_OFS_STATUS ? status_byte :
                         rd_ofs == DAG_OFS_COND   ? cond_byte :
                         rd_ofs == DAG_OFS_CB_RIC ? cb_ric_reg :
                         rd_ofs == DAG_OFS_UA_RIC ? ua_ric_reg :
                         rd_ofs == DAG_OFS_PORT4  ? port4_reg : 8'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg   <= DAG_CTRL_RST;
            cb_ric_reg <= DAG_RIC_RST;
            ua_ric_reg <= DAG_RIC_RST;
            port4_reg  <= DAG_PORT4_RST;
        end else begin
            // A high debug reset pin holds the select bit at its reset value 1, which keeps debug disabled
            if (dreset_s) begin
                ctrl_reg[DAG_CTRL_MODE_BIT] <= DAG_CTRL_RST[DAG_CTRL_MODE_BIT];
            end else if (wr_ctrl) begin
                ctrl_reg[DAG_CTRL_MODE_BIT] <= w_data_reg[DAG_CTRL_MODE_BIT];
            end
            if (wr_ctrl) begin
                ctrl_reg[DAG_CTRL_LINK_BIT] <= w_data_reg[DAG_CTRL_LINK_BIT];
            end
            if (wr_cb) begin
                cb_ric_reg <= w_data_reg[7:0];
            end
            if (wr_ua) begin
                ua_ric_reg <= w_data_reg[7:0];
            end
            if (wr_p4) begin
                port4_reg <= w_data_reg[7:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= DAG_RESP_OKAY;
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            aw_addr_reg   <= '0;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg   <= s_axi_awaddr;
                aw_have_reg   <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
                w_have_reg   <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? DAG_RESP_OKAY : DAG_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= DAG_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rdata   <= {24'h00_0000, rd_byte};
            s_axi_rresp   <= rd_known ? DAG_RESP_OKAY : DAG_RESP_SLVERR;
            s_axi_rvalid  <= 1'b1;
            s_axi_arready <= 1'b0;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    mismatch_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == DAG_CHECK && !id_match && !retry_pulse |=> !unlocked_reg ##1 !flash_read_en)
        else $error("mismatch left protection lifted");
    auth_unlock_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == DAG_CHECK && id_match && en_flag && !retry_pulse |=> unlocked_reg ##1 flash_read_en)
        else $error("matching identifier did not unlock");
    flag_needed_a: assert property (@(posedge aclk) disable iff (!aresetn)
        debug_enable |-> $past(en_flag) && $past(!mode_sel))
        else $error("debug enabled without enable flag");
    flag_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == DAG_CHECK && !en_flag && !retry_pulse |=> !unlocked_reg)
        else $error("cleared enable flag still unlocked");
    break_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
        block_common |=> !break_grant)
        else $error("forced break granted while blocked");
    monitor_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (block_common || (link_async && !async_rate_ok)) |=> !monitor_grant && !dmm_wr_grant && !standby_release)
        else $error("monitor or memory write under blocking condition");
    standby_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
        dbg_monitor_req && monitor_ok && standby_active && !link_async |=> standby_release)
        else $error("standby not released on clocked link");
    unlock_seq_a: assert property (@(posedge aclk) disable iff (!aresetn)
        dmm_wr_req && dmm_target_protected |=> !dmm_wr_grant && dmm_wr_reject)
        else $error("write reached special-sequence register");
    reset_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> !unlocked_reg ##1 !flash_read_en && !debug_enable)
        else $error("access open straight after reset");
endmodule

// [logic/dag_pkg.sv]
// Constants, register map and types of the debug access security gate
package dag_pkg;
    localparam int          DAG_ID_BYTES    = 10;
    localparam logic [31:0] DAG_ID_FIRST    = 32'h0000_0070;
    localparam logic [31:0] DAG_ID_LAST     = 32'h0000_0079;
    localparam int          DAG_EN_FLAG_BIT = 7;
    localparam logic [7:0]  DAG_MONITOR_FILL = 8'hff;

    localparam logic [7:0] DAG_OFS_CTRL   = 8'h00;
    localparam logic [7:0] DAG_OFS_STATUS = 8'h04;
    localparam logic [7:0] DAG_OFS_COND   = 8'h08;
    localparam logic [7:0] DAG_OFS_CB_RIC = 8'h0c;
    localparam logic [7:0] DAG_OFS_UA_RIC = 8'h10;
    localparam logic [7:0] DAG_OFS_PORT4  = 8'h14;

    localparam int DAG_CTRL_MODE_BIT  = 0;
    localparam int DAG_CTRL_LINK_BIT  = 1;
    localparam int DAG_CTRL_RETRY_BIT = 2;
    localparam int DAG_RIC_MASK_BIT   = 6;

    localparam logic [7:0] DAG_CTRL_RST  = 8'h01;
    localparam logic [7:0] DAG_RIC_RST   = 8'h47;
    localparam logic [7:0] DAG_PORT4_RST = 8'h00;

    localparam logic [1:0] DAG_RESP_OKAY   = 2'h0;
    localparam logic [1:0] DAG_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        DAG_IDLE  = 2'h0,
        DAG_RECV  = 2'h1,
        DAG_CHECK = 2'h3,
        DAG_HOLD  = 2'h2
    } dag_auth_type;
endpackage

// [logic/dag_sync.sv]
// Two-stage synchroniser for pins from outside the aclk domain
`timescale 1ns/100ps
module dag_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1_reg <= '0;
            sync_out   <= '0;
        end else begin
            stage1_reg <= async_in;
            sync_out   <= stage1_reg;
        end
    end
endmodule

// [logic/dag_byte_rx.sv]
// Byte receiver for the clocked serial link, sampled on aclk
`timescale 1ns/100ps
module dag_byte_rx (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       sck_s,
    input  wire logic       sin_s,
    input  wire logic       clear,
    output logic            byte_valid,
    output logic      [7:0] byte_data
);
    logic       sck_prev_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    wire        sck_rise = sck_s & ~sck_prev_reg;
    wire [7:0]  shift_next = {shift_reg[6:0], sin_s};

    // Data is taken MSB first on the rising link clock edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sck_prev_reg <= 1'b0;
            bit_cnt_reg  <= 3'h0;
            shift_reg    <= 8'h00;
            byte_valid   <= 1'b0;
            byte_data    <= 8'h00;
        end else begin
            sck_prev_reg <= sck_s;
            byte_valid   <= 1'b0;
            if (clear) begin
                bit_cnt_reg <= 3'h0;
            end else if (sck_rise) begin
                shift_reg   <= shift_next;
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == 3'h7) begin
                    byte_valid <= 1'b1;
                    byte_data  <= shift_next;
                end
            end
        end
    end

    byte_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
        byte_valid |-> $past(sck_rise) && !$past(clear) && $past(bit_cnt_reg) == 3'h7)
        else $error("byte strobe without eighth link clock edge");
endmodule

// [tb/dag_emu.sv]
// Behavioural emulator on the clocked serial debug link
`timescale 1ns/100ps
module dag_emu (
    output logic sck,
    output logic sdo
);
    initial begin
        sck = 1'b0;
        sdo = 1'b1;
    end
    // Clock stands low between frames; data then shows the inverse of its last bit
    task automatic send(input logic [79:0] id);
        // Keep link edges away from the aclk sampling edge
        #10;
        for (int i = 0; i < 80; i++) begin
            sdo = id[8 * (i / 8) + 7 - (i % 8)];
            #200 sck = 1'b1;
            #200 sck = 1'b0;
        end
        sdo = ~sdo;
    endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench of the debug access security gate
`timescale 1ns/100ps
module testbench import dag_pkg::*; ;
    localparam logic [79:0] ID = 80'hd423f1debc9a78563412;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [79:0] flash_id;
    logic clocked_serial_clock, clocked_serial_in, clocked_serial_out, handshake_line, async_serial_tx;
    logic debug_reset_pin, cpu_int_enable, standby_active, standby_mi_release_en, main_clock_running;
    logic async_rate_ok, dbg_break_req, dbg_monitor_req, dmm_wr_req, dmm_target_protected;
    logic flash_read_en, debug_enable, break_grant, monitor_grant, dmm_wr_grant, dmm_wr_reject, standby_release;
    int n_errors, n_compared;
    dag_top DUT (.*);
    dag_emu EMU (.sck(clocked_serial_clock), .sdo(clocked_serial_in));
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        chk(n < 50, 1, "write answer");
    endtask
    task automatic axr(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        {rd, rs} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        chk(n < 50, 1, "read answer");
    endtask
    task automatic do_reset(input logic [79:0] v);
        @(posedge aclk);
        aresetn <= 1'b0;
        flash_id <= v;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    // Random conditions and requests; expectations derived from the gating conditions
    task automatic cond_round(input logic link, input logic mask, input logic de);
        logic [8:0] r;
        logic blk, run;
        r = 9'($urandom);
        axw(DAG_OFS_CTRL, {30'h0, link, 1'b0});
        axw(link ? DAG_OFS_UA_RIC : DAG_OFS_CB_RIC, {25'h0, mask, 6'h07});
        @(posedge aclk);
        {cpu_int_enable, standby_active, standby_mi_release_en, main_clock_running, async_rate_ok} <= r[4:0];
        {dmm_target_protected, dbg_break_req, dbg_monitor_req, dmm_wr_req} <= r[8:5];
        @(posedge aclk);
        @(negedge aclk);
        blk = !cpu_int_enable || mask || (standby_active && !standby_mi_release_en) || (link && !main_clock_running);
        run = de && !blk && !(link && !async_rate_ok);
        chk(break_grant, dbg_break_req && de && !blk, "break");
        chk(monitor_grant, dbg_monitor_req && run, "monitor");
        chk(dmm_wr_grant, dmm_wr_req && run && !dmm_target_protected, "dmm");
        chk(standby_release, standby_active && (dbg_monitor_req || dmm_wr_req) && run, "wake");
        chk(dmm_wr_reject, dmm_wr_req && !(run && !dmm_target_protected), "reject");
        axr(DAG_OFS_COND);
        chk(rd, {26'h0, !link || main_clock_running, mask, blk, run, de && !blk, 1'b0}, "cond");
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0, 32'h0, 4'hf};
        {debug_reset_pin, cpu_int_enable, standby_active, standby_mi_release_en} = '0;
        {main_clock_running, async_rate_ok, dmm_target_protected} = '0;
        {dbg_break_req, dbg_monitor_req, dmm_wr_req, n_errors, n_compared} = '0;
        flash_id = ID;
        void'($urandom(20494));
        do_reset(ID);
        axr(DAG_OFS_CTRL);
        chk(rd, 32'h01, "ctrl reset");
        axr(DAG_OFS_CB_RIC);
        chk(rd, 32'h47, "cb ric reset");
        axr(DAG_OFS_UA_RIC);
        chk(rd, 32'h47, "ua ric reset");
        axr(DAG_OFS_PORT4);
        chk(rd, 32'h00, "port4 reset");
        axr(8'h18);
        chk(rd, 32'h0, "unmapped data");
        chk(rs, DAG_RESP_SLVERR, "unmapped read");
        axw(DAG_OFS_PORT4, 32'h07);
        axw(DAG_OFS_PORT4, 32'h07);
        chk(rs, DAG_RESP_OKAY, "write okay");
        axr(DAG_OFS_PORT4);
        chk(rd, 32'h07, "port4 kept");
        axw(8'h18, 32'h0);
        chk(rs, DAG_RESP_SLVERR, "unmapped write");
        chk(flash_read_en, 0, "locked after reset");
        $display("test reset values done");
        debug_reset_pin <= 1'b1;
        repeat (4) @(posedge aclk);
        axw(DAG_OFS_CTRL, 32'h0);
        axr(DAG_OFS_CTRL);
        chk(rd[0], 1, "select held by pin");
        debug_reset_pin <= 1'b0;
        repeat (4) @(posedge aclk);
        axw(DAG_OFS_CTRL, 32'h0);
        axr(DAG_OFS_CTRL);
        chk(rd[0], 0, "select cleared");
        EMU.send(ID ^ (80'h1 << ($urandom % 79)));
        repeat (20) @(posedge aclk);
        chk({flash_read_en, debug_enable}, 0, "wrong id");
        axr(DAG_OFS_STATUS);
        chk(rd, 32'hb8, "status mismatch");
        axw(DAG_OFS_CTRL, 32'h4);
        EMU.send(ID);
        repeat (20) @(posedge aclk);
        chk({flash_read_en, debug_enable}, 3, "right id");
        chk({clocked_serial_out, handshake_line, async_serial_tx}, 7, "link pins");
        axr(DAG_OFS_STATUS);
        chk(rd, 32'hbf, "status unlocked");
        // Erased filler bytes after a verdict must leave it alone
        EMU.send({10{DAG_MONITOR_FILL}});
        repeat (20) @(posedge aclk);
        chk({flash_read_en, debug_enable}, 3, "bytes after verdict");
        $display("test identifier done");
        for (int i = 0; i < 40; i++) cond_round(1'($urandom), ($urandom % 4) == 0, 1'b1);
        axw(DAG_OFS_CTRL, 32'h1);
        repeat (2) @(posedge aclk);
        chk({flash_read_en, debug_enable}, 2, "select set");
        $display("test conditions done");
        do_reset(ID & ~(80'h1 << 79));
        axw(DAG_OFS_CTRL, 32'h0);
        EMU.send(ID & ~(80'h1 << 79));
        repeat (20) @(posedge aclk);
        chk({flash_read_en, debug_enable}, 0, "flag clear");
        axr(DAG_OFS_STATUS);
        chk(rd, 32'hb4, "status flag clear");
        for (int i = 0; i < 8; i++) cond_round(1'($urandom), 1'b0, 1'b0);
        $display("test enable flag done");
        end_sim();
    end
    initial begin
        #1000000;
        n_errors++;
        end_sim();
    end
endmodule
